// ===== verilog/homing_map.svh
// homing sequencer constants: method codes and defaults
`ifndef HOMING_MAP_SVH
`define HOMING_MAP_SVH
`define HM_DEFAULT_METHOD 8'sh13
`define HM_FAST_SPEED_DEFAULT 32'h00002710
`define HM_SLOW_SPEED_DEFAULT 32'h00001388
`define HM_ACCEL_DEFAULT 32'h00001388
`define HM_TORQUE_LOW_MIN (-6)
`define HM_TORQUE_IDX_MAX (-1)
`define HM_SWITCH_MAX 14
`define HM_DIRECT_OFFSET 16
`define HM_DIRECT_MAX 32
`define HM_INDEX_NEG 33
`define HM_INDEX_POS 34
`define HM_HERE_MIN 35
`define HM_HERE_MAX 37
`endif

// ===== verilog/homing_pkg.sv
// homing sequencer types
package homing_pkg;
    typedef logic signed [7:0] method_t;
    typedef logic [31:0] speed_t;
    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_SEEK   = 7'h02,
        ST_BACK   = 7'h04,
        ST_EDGE   = 7'h08,
        ST_INDEX  = 7'h10,
        ST_DONE   = 7'h20,
        ST_ERROR  = 7'h40
    } state_e;
endpackage

// ===== verilog/homing_method_sequencer.sv
// homing method sequencer: search speed, direction and home event per method code
`include "homing_map.svh"
module homing_method_sequencer #(
    parameter logic [31:0] FAST_SPEED_DEFAULT = `HM_FAST_SPEED_DEFAULT,
    parameter logic [31:0] SLOW_SPEED_DEFAULT = `HM_SLOW_SPEED_DEFAULT
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // command
    input wire logic start_i,
    input wire homing_pkg::method_t method_i,
    input wire homing_pkg::speed_t fast_speed_i,
    input wire homing_pkg::speed_t slow_speed_i,
    input wire homing_pkg::speed_t accel_i,
    // sensors
    input wire logic neg_limit_i,
    input wire logic pos_limit_i,
    input wire logic home_sw_i,
    input wire logic index_i,
    input wire logic torque_limit_i,
    // motion profile
    output logic move_o,
    output logic dir_pos_o,
    output homing_pkg::speed_t speed_o,
    output homing_pkg::speed_t accel_o,
    output logic set_home_o,
    output logic busy_o,
    output logic done_o,
    output logic error_o
);
    import homing_pkg::*;

    state_e state_q, state_d;
    logic dir_q, dir_d;
    logic fast_q, fast_d;
    logic move_q, move_d;
    logic set_home_q, set_home_d;
    logic done_q, done_d;
    logic error_q, error_d;
    logic use_index_q, use_index_d;
    logic far_q, far_d;
    logic want_rise_q, want_rise_d;
    logic torque_q, torque_d;
    logic prev_sw_q;
    speed_t accel_q;

    // selected trigger level and its edges
    logic trig_now;
    logic trig_rise;
    logic trig_fall;
    method_t base;
    always_comb begin
        if (method_i > 8'sd`HM_DIRECT_OFFSET && method_i <= 8'sd`HM_DIRECT_MAX)
            base = method_t'(method_i - 8'sd`HM_DIRECT_OFFSET);
        else
            base = method_i;
    end
    always_comb begin
        trig_now = torque_q ? torque_limit_i :
                   (base == 8'sd1) ? neg_limit_i :
                   (base == 8'sd2) ? pos_limit_i : home_sw_i;
    end
    assign trig_rise = trig_now & ~prev_sw_q;
    assign trig_fall = ~trig_now & prev_sw_q;

    // sequence next-state logic
    always_comb begin
        state_d = state_q;
        dir_d = dir_q;
        fast_d = fast_q;
        move_d = move_q;
        set_home_d = 1'b0;
        done_d = done_q;
        error_d = error_q;
        use_index_d = use_index_q;
        far_d = far_q;
        want_rise_d = want_rise_q;
        torque_d = torque_q;
        case (state_q)
            ST_IDLE, ST_DONE, ST_ERROR: begin
                if (start_i) begin
                    done_d = 1'b0;
                    error_d = 1'b0;
                    torque_d = 1'b0;
                    far_d = 1'b0;
                    use_index_d = 1'b1;
                    want_rise_d = 1'b0;
                    fast_d = 1'b1;
                    move_d = 1'b1;
                    state_d = ST_SEEK;
                    if (method_i >= method_t'(`HM_TORQUE_LOW_MIN) && method_i <= method_t'(`HM_TORQUE_IDX_MAX)) begin
                        torque_d = 1'b1;
                        dir_d = method_i[0]; // odd codes run positive
                        fast_d = (method_i > -8'sd5);
                        use_index_d = (method_i >= -8'sd2);
                    end else if (base >= 8'sd1 && base <= 8'sd`HM_SWITCH_MAX) begin
                        dir_d = (base == 8'sd2) || (base == 8'sd3) || (base == 8'sd4) ||
                                (base == 8'sd7) || (base == 8'sd8) || (base == 8'sd9) || (base == 8'sd10);
                        want_rise_d = (base == 8'sd4) || (base == 8'sd6) || (base == 8'sd8) ||
                                      (base == 8'sd9) || (base == 8'sd12) || (base == 8'sd13);
                        far_d = (base == 8'sd13) || (base == 8'sd14);
                        use_index_d = (method_i <= 8'sd`HM_SWITCH_MAX);
                    end else if (method_i == 8'sd`HM_INDEX_NEG || method_i == 8'sd`HM_INDEX_POS) begin
                        dir_d = (method_i == 8'sd`HM_INDEX_POS);
                        fast_d = 1'b0;
                        state_d = ST_INDEX;
                    end else if (method_i >= 8'sd`HM_HERE_MIN && method_i <= 8'sd`HM_HERE_MAX) begin
                        move_d = 1'b0;
                        state_d = ST_DONE;
                        set_home_d = 1'b1;
                        done_d = 1'b1;
                    end else begin
                        move_d = 1'b0;
                        error_d = 1'b1;
                        state_d = ST_ERROR;
                    end
                end
            end
            ST_SEEK: begin
                // deceleration point reached: torque limit or selected switch
                if (trig_rise) begin
                    fast_d = 1'b0;
                    if (torque_q && method_i <= -8'sd5) begin
                        state_d = ST_DONE;
                    end else if (!torque_q && !use_index_q) begin
                        state_d = ST_DONE;
                    end else if (torque_q || base <= 8'sd2) begin
                        dir_d = ~dir_q;
                        state_d = ST_BACK;
                    end else if (want_rise_q && !far_q) begin
                        state_d = ST_INDEX; // the approach-side rise is the wanted edge itself
                    end else begin
                        if (!far_q) dir_d = ~dir_q; // back out through the approach side
                        state_d = ST_EDGE;
                    end
                    if (state_d == ST_DONE) begin
                        move_d = 1'b0;
                        set_home_d = 1'b1;
                        done_d = 1'b1;
                    end
                end
            end
            ST_BACK: begin
                // limit or torque released after reversal
                if (trig_fall) begin
                    if (torque_q && !use_index_q) begin
                        move_d = 1'b0;
                        set_home_d = 1'b1;
                        done_d = 1'b1;
                        state_d = ST_DONE;
                    end else begin
                        state_d = ST_INDEX;
                    end
                end
            end
            ST_EDGE: begin
                // home switch edge on the chosen side; a far-side rise needs a turn back to meet it
                if (far_q && want_rise_q && trig_fall) begin
                    dir_d = ~dir_q;
                end else if (want_rise_q ? trig_rise : trig_fall) begin
                    // turn once more so the index searched lies beyond the switch
                    if (far_q && want_rise_q) dir_d = ~dir_q;
                    state_d = ST_INDEX;
                end
            end
            ST_INDEX: begin
                if (index_i) begin
                    move_d = 1'b0;
                    set_home_d = 1'b1;
                    done_d = 1'b1;
                    state_d = ST_DONE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                move_d = 1'b0;
            end
        endcase
    end

    // state registers
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= ST_IDLE;
            dir_q <= 1'b0;
            fast_q <= 1'b0;
            move_q <= 1'b0;
            set_home_q <= 1'b0;
            done_q <= 1'b0;
            error_q <= 1'b0;
            use_index_q <= 1'b0;
            far_q <= 1'b0;
            want_rise_q <= 1'b0;
            torque_q <= 1'b0;
            prev_sw_q <= 1'b0;
            accel_q <= 32'h00000000;
        end else begin
            state_q <= state_d;
            dir_q <= dir_d;
            fast_q <= fast_d;
            move_q <= move_d;
            set_home_q <= set_home_d;
            done_q <= done_d;
            error_q <= error_d;
            use_index_q <= use_index_d;
            far_q <= far_d;
            want_rise_q <= want_rise_d;
            torque_q <= torque_d;
            prev_sw_q <= trig_now;
            accel_q <= accel_i; // one setting for both ramps
        end
    end

    // speed register picks fast or slow setting
    speed_t speed_q;
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            speed_q <= 32'h00000000;
        else
            speed_q <= move_d ? (fast_d ? fast_speed_i : slow_speed_i) : 32'h00000000;
    end

    assign move_o = move_q;
    assign dir_pos_o = dir_q;
    assign speed_o = speed_q;
    assign accel_o = accel_q;
    assign set_home_o = set_home_q;
    assign busy_o = move_q;
    assign done_o = done_q;
    assign error_o = error_q;
endmodule

// ===== test/homing_method_sequencer_asserts.sv
// port checker for the homing sequencer
module homing_checker (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // command
    input wire logic start_i,
    input wire homing_pkg::method_t method_i,
    input wire homing_pkg::speed_t fast_speed_i,
    input wire homing_pkg::speed_t slow_speed_i,
    input wire homing_pkg::speed_t accel_i,
    // motion profile
    input wire logic move_o,
    input wire logic dir_pos_o,
    input wire homing_pkg::speed_t speed_o,
    input wire homing_pkg::speed_t accel_o,
    input wire logic set_home_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic error_o
);
    import homing_pkg::*;
    logic take;
    // a start counts only while nothing moves, later ones are refused
    assign take = start_i && !move_o;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_accel_shared: assert property (!$past(sys_rst_i) |-> accel_o == $past(accel_i)) else $error("accel lag");
    a_busy_motion: assert property (busy_o == move_o) else $error("busy differs");
    a_rest_speed: assert property (!move_o |-> speed_o == '0) else $error("speed at rest");
    a_torque_slow: assert property (take && (method_i == -6 || method_i == -5) |=>
        move_o && speed_o == slow_speed_i && dir_pos_o == $past(method_i[0])) else $error("torque start");
    a_seek_fast: assert property (take && ((method_i >= 1 && method_i <= 14) || (method_i >= -4 && method_i <= -1))
        |=> move_o && speed_o == fast_speed_i) else $error("seek speed");
    a_index_dir: assert property (take && (method_i == 33 || method_i == 34) |=>
        move_o && dir_pos_o == !$past(method_i[0])) else $error("index dir");
    a_here_home: assert property (take && method_i >= 35 && method_i <= 37 |=>
        set_home_o && done_o && !move_o) else $error("here home");
    a_bad_code: assert property (take && (method_i < -6 || method_i == 0 || method_i == 15 || method_i == 16
        || method_i > 37) |=> error_o && !move_o && !done_o) else $error("bad code");
    a_home_pulse: assert property (set_home_o |=> !set_home_o) else $error("home pulse");
    a_home_stop: assert property (set_home_o |-> !move_o && done_o) else $error("home stop");
    a_done_hold: assert property (done_o && !start_i |=> done_o) else $error("done drop");
endmodule
bind homing_method_sequencer homing_checker u_chk (.*);

// ===== test/axis_model.sv
// behavioural axis: hard stops, limit switches, home switch and index marks
module axis_model #(
    parameter int LIMIT = 200,
    parameter int STOP = 220,
    parameter int SW_LO = 40,
    parameter int SW_HI = 60,
    parameter int PITCH = 16
) (
    // clock and drive command
    input wire logic sys_clk_i,
    input wire logic move_i,
    input wire logic dir_pos_i,
    input wire logic load_i,
    input wire logic signed [15:0] load_pos_i,
    // sensors and position
    output logic neg_limit_o,
    output logic pos_limit_o,
    output logic home_sw_o,
    output logic index_o,
    output logic torque_limit_o,
    output logic signed [15:0] pos_o
);
    logic signed [15:0] pos_q = '0;
    // one count per cycle; the hard stops clamp it so torque builds there
    always @(posedge sys_clk_i) begin
        if (load_i) pos_q <= load_pos_i;
        else if (move_i && dir_pos_i && pos_q < STOP) pos_q <= pos_q + 1;
        else if (move_i && !dir_pos_i && pos_q > -STOP) pos_q <= pos_q - 1;
    end
    // sensors follow position; the index stays high while parked on a mark
    assign neg_limit_o = pos_q <= -LIMIT;
    assign pos_limit_o = pos_q >= LIMIT;
    assign home_sw_o = pos_q >= SW_LO && pos_q <= SW_HI;
    assign index_o = pos_q % PITCH == 0;
    assign torque_limit_o = move_i && (dir_pos_i ? pos_q >= STOP : pos_q <= -STOP);
    assign pos_o = pos_q;
endmodule

// ===== test/homing_method_sequencer_bench.sv
// self-checking bench for the homing sequencer against an axis model
module homing_method_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import homing_pkg::*;
    typedef struct {logic err; logic signed [15:0] pos;} note_s;
    logic sys_clk_i = 0, sys_rst_i = 1, start_i = 0, load_i = 0, err_seen_q = 0;
    method_t method_i = 0;
    speed_t fast_speed_i = 0, slow_speed_i = 0, accel_i = 0, speed_o, accel_o;
    logic neg_limit_i, pos_limit_i, home_sw_i, index_i, torque_limit_i;
    logic move_o, dir_pos_o, set_home_o, busy_o, done_o, error_o;
    logic signed [15:0] load_pos = 0, pos, r, base;
    int failures = 0, checks = 0, cycles = 0;
    note_s notes[$];
    always #2.5 sys_clk_i = ~sys_clk_i;
    homing_method_sequencer uut (.*);
    axis_model axis (.sys_clk_i(sys_clk_i), .move_i(move_o), .dir_pos_i(dir_pos_o), .load_i(load_i),
        .load_pos_i(load_pos), .neg_limit_o(neg_limit_i), .pos_limit_o(pos_limit_i), .home_sw_o(home_sw_i),
        .index_o(index_i), .torque_limit_o(torque_limit_i), .pos_o(pos));
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard: the longest search is a few hundred cycles
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            complete_run();
        end
    end
    // each home pulse or fresh error takes the oldest note; stop overshoot of 3 counts is tolerated
    always @(posedge sys_clk_i) begin
        note_s n;
        err_seen_q <= error_o;
        if (!sys_rst_i && (set_home_o === 1'b1 || (error_o === 1'b1 && !err_seen_q))) begin
            if (notes.size() == 0) check("extra result", 1, 0);
            else begin
                n = notes.pop_front();
                check("error flag", error_o, n.err);
                if (!n.err) check("home pos", (pos - n.pos <= 3 && n.pos - pos <= 3) ? n.pos : pos, n.pos);
            end
        end
    end
    // place the axis, start one method and wait for its end
    task automatic run(method_t m, logic signed [15:0] at, logic e, logic signed [15:0] home);
        int n = 0;
        notes.push_back('{e, home});
        load_pos = at;
        load_i = 1;
        method_i = m;
        accel_i = $urandom;
        @(posedge sys_clk_i) #1;
        load_i = 0;
        start_i = 1;
        @(posedge sys_clk_i) #1;
        start_i = 0;
        while (done_o !== 1'b1 && error_o !== 1'b1 && n < 2000) begin
            @(posedge sys_clk_i) #1;
            n++;
        end
        if (n == 2000) check("finished", 0, 1);
    endtask
    // error codes sit between good ones so each error flag rises afresh
    initial begin
        void'($urandom(3733));
        fast_speed_i = $urandom;
        slow_speed_i = $urandom;
        r = 16 * (4 + $urandom % 7) + 1 + $urandom % 15;
        base = r - r % 16;
        repeat (2) @(posedge sys_clk_i);
        #1 sys_rst_i = 0;
        run(33, r, 0, base);
        run(0, 0, 1, 0);
        run(34, r, 0, base + 16);
        run(15, 0, 1, 0);
        run(1, 0, 0, -192);
        run(38, 0, 1, 0);
        run(2, 0, 0, 192);
        run(-7, 0, 1, 0);
        run(3, 0, 0, 32);
        run(5, 100, 0, 64);
        run(4, 0, 0, 48);
        run(6, 100, 0, 48);
        run(13, 100, 0, 32);
        run(14, 100, 0, 32);
        run(18, 0, 0, 200);
        run(17, 0, 0, -200);
        run(19, 0, 0, 40);
        run(-6, 0, 0, -220);
        run(-5, 0, 0, 220);
        run(-4, 0, 0, -219);
        run(-3, 0, 0, 219);
        run(-2, 0, 0, -208);
        run(-1, 0, 0, 208);
        for (int m = 35; m <= 37; m++) run(m, r + m, 0, r + m);
        repeat (3) @(posedge sys_clk_i);
        complete_run();
    end
endmodule
